//--- rtl/sdmr_pkg.sv
// Constants, command and state types for the memory device command logic.
// Assumes one 200 MHz command clock and a controller that keeps its own timing.
// Operation
// - Read data appears CAS latency clocks later.
// - Write-burst bit makes writes single-location.
// - Selected no-operation leaves state unchanged.
// - Burst stop ends bursts without auto precharge.
// - Stopped read drains after CAS latency.
// - Deselect ignores strobes and address.
// - Auto refresh advances internal row counter.
// - Self-refresh ignores all but clock enable.
// - Clock enable low mid-burst freezes operation.
// - Clock enable low when idle: power-down.
// - Clock enable high restarts internal clock.
// - Data mask blocks writes, disables read drivers.
// - Mode programming loads address, takes two clocks.
`default_nettype none
package sdmr_pkg;
    localparam int          MR_W              = 13;
    localparam int          CL_LSB            = 4;
    localparam int          CL_MSB            = 6;
    localparam int          TM_LSB            = 7;
    localparam int          TM_MSB            = 8;
    localparam int          WB_BIT            = 9;
    localparam int          AP_BIT            = 10;
    localparam int          BL_MSB            = 2;
    localparam logic [2:0]  CL_TWO            = 3'h2;
    localparam logic [2:0]  CL_THREE          = 3'h3;
    localparam logic [1:0]  TM_NORMAL         = 2'h0;
    localparam logic [2:0]  BL_EIGHT          = 3'h3;
    localparam logic [2:0]  BL_FULL           = 3'h7;
    localparam logic [9:0]  FULL_PAGE_LEN     = 10'h200;
    localparam logic [1:0]  MRD_CYC           = 2'h2;
    localparam int          REFRESH_ROWS      = 8192;
    localparam int          REFRESH_PERIOD_MS = 64;
    localparam int          CLK_PERIOD_PS     = 5000;
    localparam int          SR_INT_CYC        = int'((64'(REFRESH_PERIOD_MS) * 64'd1000000000)
                                                / (64'(REFRESH_ROWS) * 64'(CLK_PERIOD_PS)));

    typedef enum logic [3:0] {
        CMD_DESEL, CMD_NOP, CMD_BSTOP, CMD_READ, CMD_WRITE,
        CMD_ACT, CMD_PRE, CMD_REF, CMD_MRS
    } sdmr_cmd_type;

    typedef enum logic [2:0] {
        ST_IDLE, ST_RD, ST_WR, ST_SELF, ST_PDN
    } sdmr_st_type;
endpackage
`default_nettype wire

//--- rtl/sdmr_refresh_ctr.sv
// Internal refresh row counter with its own self-refresh interval timer.
// Assumes the caller pulses ext_ref once per accepted refresh command.
`timescale 1ns/1ps
`default_nettype none
module sdmr_refresh_ctr #(
    parameter int ROW_W   = 13,
    parameter int INT_CYC = sdmr_pkg::SR_INT_CYC
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Refresh requests.
    input  wire logic             ext_ref,
    input  wire logic             self_mode,
    // Current row.
    output logic [ROW_W-1:0]      row_q
);
    localparam int TW = $clog2(INT_CYC);

    typedef struct packed {
        logic [ROW_W-1:0] row;
        logic [TW-1:0]    tmr;
    } sdmr_rc_type;

    sdmr_rc_type s_q;
    sdmr_rc_type s_d;
    logic        tick;

    always_comb begin
        s_d  = s_q;
        tick = 1'b0;
        if (!self_mode) begin
            s_d.tmr = '0;
        end else if (s_q.tmr == TW'(INT_CYC - 1)) begin
            s_d.tmr = '0;
            tick    = 1'b1;
        end else begin
            s_d.tmr = s_q.tmr + TW'(1);
        end
        if (ext_ref || tick) begin
            s_d.row = s_q.row + ROW_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign row_q = s_q.row;
endmodule
`default_nettype wire

//--- rtl/sdmr_device.sv
// Command decoder, mode register, burst, refresh and power states of the memory.
// Assumes commands sampled on the rising clk edge and a split data pin.
`timescale 1ns/1ps
`default_nettype none
module sdmr_device #(
    parameter int COL_W      = 9,
    parameter int ROW_W      = 13,
    parameter int DQ_W       = 16,
    parameter int SR_INT_CYC = sdmr_pkg::SR_INT_CYC
) (
    // Clock and reset.
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // Command pins.
    input  wire logic                     cke,
    input  wire logic                     cs_n,
    input  wire logic                     ras_n,
    input  wire logic                     cas_n,
    input  wire logic                     we_n,
    input  wire logic [1:0]               ba,
    input  wire logic [sdmr_pkg::MR_W-1:0] addr,
    // Data pins.
    input  wire logic                     dqm,
    input  wire logic [DQ_W-1:0]          dq_in,
    output logic      [DQ_W-1:0]          dq_out,
    output logic                          dq_oe,
    // Status.
    output logic [sdmr_pkg::MR_W-1:0]     mode_reg,
    output logic                          cfg_error,
    output logic                          power_down,
    output logic                          self_refresh,
    output logic [ROW_W-1:0]              refresh_row
);
    typedef struct packed {
        sdmr_pkg::sdmr_st_type       st;
        logic                        cke_q;
        logic [sdmr_pkg::MR_W-1:0]   mode;
        logic [9:0]                  cnt;
        logic [COL_W-1:0]            col;
        logic                        ap;
        logic [2:0]                  pipe_v;
        logic [2:0][COL_W-1:0]       pipe_a;
        logic [DQ_W-1:0]             dq;
        logic                        oe;
        logic [1:0]                  mrd;
        logic                        err;
        logic                        pdn;
        logic                        sr;
    } sdmr_state_type;

    function automatic sdmr_pkg::sdmr_cmd_type cmd_decode(input logic c, r, a, w);
        if (c) return sdmr_pkg::CMD_DESEL;
        case ({r, a, w})
            3'h7:    return sdmr_pkg::CMD_NOP;
            3'h6:    return sdmr_pkg::CMD_BSTOP;
            3'h5:    return sdmr_pkg::CMD_READ;
            3'h4:    return sdmr_pkg::CMD_WRITE;
            3'h3:    return sdmr_pkg::CMD_ACT;
            3'h2:    return sdmr_pkg::CMD_PRE;
            3'h1:    return sdmr_pkg::CMD_REF;
            default: return sdmr_pkg::CMD_MRS;
        endcase
    endfunction

    function automatic logic [9:0] burst_len(input logic [sdmr_pkg::MR_W-1:0] m);
        if (m[sdmr_pkg::BL_MSB:0] == sdmr_pkg::BL_FULL) return sdmr_pkg::FULL_PAGE_LEN;
        if (m[sdmr_pkg::BL_MSB:0] > sdmr_pkg::BL_EIGHT) return 10'h1;
        return 10'h1 << m[sdmr_pkg::BL_MSB:0];
    endfunction

    sdmr_state_type          s_q;
    sdmr_state_type          s_d;
    sdmr_pkg::sdmr_cmd_type  cmd;
    logic [DQ_W-1:0]         mem [2**COL_W];
    logic                    mem_we;
    logic [COL_W-1:0]        mem_a;
    logic                    ref_go;
    logic                    issue;
    logic                    clk_on;
    logic [1:0]              stage;
    logic [2:0]              cl;
    logic [9:0]              len;

    assign clk_on = s_q.cke_q;
    assign cmd    = cmd_decode(cs_n, ras_n, cas_n, we_n);
    assign cl     = s_q.mode[sdmr_pkg::CL_MSB:sdmr_pkg::CL_LSB];
    assign stage  = (cl == sdmr_pkg::CL_TWO) ? 2'h1 : 2'h2;
    assign len    = s_q.mode[sdmr_pkg::WB_BIT] && cmd == sdmr_pkg::CMD_WRITE ? 10'h1 :
                    burst_len(s_q.mode);

    always_comb begin
        s_d      = s_q;
        ref_go   = 1'b0;
        mem_we   = 1'b0;
        mem_a    = s_q.col;
        issue    = 1'b0;
        s_d.cke_q = cke;
        if (s_q.st == sdmr_pkg::ST_SELF) begin
            if (cke) begin
                s_d.st = sdmr_pkg::ST_IDLE;
            end
        end else if (!clk_on) begin
            if (s_q.st == sdmr_pkg::ST_PDN && cke) begin
                s_d.st = sdmr_pkg::ST_IDLE;
            end
        end else begin
            s_d.dq     = mem[s_q.pipe_a[0]];
            s_d.oe     = s_q.pipe_v[0] && !dqm;
            s_d.pipe_v = {1'b0, s_q.pipe_v[2:1]};
            s_d.pipe_a = {{COL_W{1'b0}}, s_q.pipe_a[2:1]};
            if (s_q.mrd != 2'h0) begin
                s_d.mrd = s_q.mrd - 2'h1;
            end
            case (s_q.st)
                sdmr_pkg::ST_RD, sdmr_pkg::ST_WR: begin
                    if (cmd == sdmr_pkg::CMD_BSTOP && !s_q.ap) begin
                        s_d.st = sdmr_pkg::ST_IDLE;
                    end else begin
                        issue   = 1'b1;
                        s_d.cnt = s_q.cnt - 10'h1;
                        if (s_q.cnt == 10'h1) begin
                            s_d.st = sdmr_pkg::ST_IDLE;
                        end
                    end
                end
                sdmr_pkg::ST_IDLE: begin
                    if (s_q.mrd == 2'h0) begin
                        case (cmd)
                            sdmr_pkg::CMD_READ, sdmr_pkg::CMD_WRITE: begin
                                issue   = 1'b1;
                                mem_a   = addr[COL_W-1:0];
                                s_d.ap  = addr[sdmr_pkg::AP_BIT];
                                s_d.cnt = len - 10'h1;
                                if (len != 10'h1) begin
                                    s_d.st = (cmd == sdmr_pkg::CMD_READ) ? sdmr_pkg::ST_RD :
                                             sdmr_pkg::ST_WR;
                                end
                            end
                            sdmr_pkg::CMD_REF: begin
                                ref_go = 1'b1;
                                if (!cke) begin
                                    s_d.st = sdmr_pkg::ST_SELF;
                                    s_d.oe = 1'b0;
                                end
                            end
                            sdmr_pkg::CMD_MRS: begin
                                s_d.mode = addr;
                                s_d.mrd  = sdmr_pkg::MRD_CYC - 2'h1;
                                s_d.err  = !(addr[sdmr_pkg::CL_MSB:sdmr_pkg::CL_LSB] ==
                                             sdmr_pkg::CL_TWO ||
                                             addr[sdmr_pkg::CL_MSB:sdmr_pkg::CL_LSB] ==
                                             sdmr_pkg::CL_THREE) ||
                                           addr[sdmr_pkg::TM_MSB:sdmr_pkg::TM_LSB] !=
                                           sdmr_pkg::TM_NORMAL;
                            end
                            default: begin
                            end
                        endcase
                    end
                    if (!cke && s_d.st == sdmr_pkg::ST_IDLE) begin
                        s_d.st = sdmr_pkg::ST_PDN;
                        s_d.oe = 1'b0;
                    end
                end
                default: s_d.st = sdmr_pkg::ST_IDLE;
            endcase
            if (issue) begin
                s_d.col = mem_a + COL_W'(1);
                if (cmd == sdmr_pkg::CMD_READ || s_q.st == sdmr_pkg::ST_RD) begin
                    s_d.pipe_v[stage] = 1'b1;
                    s_d.pipe_a[stage] = mem_a;
                end else begin
                    mem_we = !dqm;
                end
            end
        end
        s_d.pdn = (s_d.st == sdmr_pkg::ST_PDN);
        s_d.sr  = (s_d.st == sdmr_pkg::ST_SELF);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_a] <= dq_in;
        end
    end

    sdmr_refresh_ctr #(
        .ROW_W   (ROW_W),
        .INT_CYC (SR_INT_CYC)
    ) u_refresh (
        .clk       (clk),
        .rst_n     (rst_n),
        .ext_ref   (ref_go),
        .self_mode (s_q.sr),
        .row_q     (refresh_row)
    );

    assign dq_out       = s_q.dq;
    assign dq_oe        = s_q.oe;
    assign mode_reg     = s_q.mode;
    assign cfg_error    = s_q.err;
    assign power_down   = s_q.pdn;
    assign self_refresh = s_q.sr;

    logic rd_go;
    logic stop_rd;
    assign rd_go   = clk_on && s_q.st == sdmr_pkg::ST_IDLE && s_q.mrd == 2'h0 &&
                     cmd == sdmr_pkg::CMD_READ;
    assign stop_rd = clk_on && s_q.st == sdmr_pkg::ST_RD && cmd == sdmr_pkg::CMD_BSTOP &&
                     !s_q.ap;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_read_latency: assert property (
        rd_go && cl == sdmr_pkg::CL_TWO && cke ##1 cke ##1 !dqm |=> dq_oe)
        else $error("read data late");
    chk_nop_hold: assert property (
        clk_on && cke && cmd == sdmr_pkg::CMD_NOP && s_q.st == sdmr_pkg::ST_IDLE
        |=> $stable(mode_reg) && s_q.st == sdmr_pkg::ST_IDLE)
        else $error("nop changed state");
    chk_single_write: assert property (
        clk_on && s_q.st == sdmr_pkg::ST_IDLE && s_q.mrd == 2'h0 &&
        cmd == sdmr_pkg::CMD_WRITE && s_q.mode[sdmr_pkg::WB_BIT] && cke
        |=> s_q.st == sdmr_pkg::ST_IDLE) else $error("write burst not single");
    chk_bstop_end: assert property (stop_rd |=> s_q.st == sdmr_pkg::ST_IDLE)
        else $error("burst stop ignored");
    chk_bstop_drain: assert property (
        stop_rd && cke ##1 (cke && cmd != sdmr_pkg::CMD_READ)[*2] |=> s_q.pipe_v == 3'h0)
        else $error("read data still driven");
    chk_deselect: assert property (
        cs_n && clk_on && cke && s_q.st == sdmr_pkg::ST_IDLE
        |=> s_q.st == sdmr_pkg::ST_IDLE && $stable(mode_reg))
        else $error("deselect acted");
    chk_ref_adv: assert property (
        ref_go && !self_refresh |=> refresh_row == $past(refresh_row) + ROW_W'(1))
        else $error("refresh row stuck");
    chk_self_ignore: assert property (
        self_refresh && !cke |=> self_refresh && $stable(mode_reg))
        else $error("self refresh left");
    chk_suspend_freeze: assert property (
        (s_q.st == sdmr_pkg::ST_RD || s_q.st == sdmr_pkg::ST_WR) && !clk_on
        |=> $stable(s_q.cnt) && $stable(dq_oe))
        else $error("suspend not frozen");
    chk_pdn_buffers: assert property (power_down |-> !dq_oe)
        else $error("driver on in power-down");
    chk_wake: assert property (power_down && cke |=> !power_down)
        else $error("power-down not left");
    chk_dqm_mask: assert property (
        clk_on && s_q.pipe_v[0] && dqm && !power_down |=> !dq_oe)
        else $error("masked read driven");
    chk_mode_load: assert property (
        clk_on && cke && s_q.st == sdmr_pkg::ST_IDLE && s_q.mrd == 2'h0 &&
        cmd == sdmr_pkg::CMD_MRS |=> mode_reg == $past(addr) ##1 s_q.mrd == 2'h0)
        else $error("mode load wrong");

    cov_read: cover property (rd_go ##[1:4] dq_oe);
    cov_self: cover property (self_refresh ##1 !self_refresh);
    cov_pdn: cover property (power_down ##1 !power_down);
    cov_stop: cover property (stop_rd);
endmodule
`default_nettype wire

//--- bench/sdmr_ctrl_model.sv
// Controller model driving the command, mask and write data pins of the memory.
// Assumes it is the only driver of these pins and the clock runs freely.
`timescale 1ns/1ps
`default_nettype none
module sdmr_ctrl_model (
    // Clock.
    input  wire logic        clk,
    // Command pins.
    output logic             cke,
    output logic             cs_n,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic [1:0]       ba,
    output logic [12:0]      addr,
    // Data pins.
    output logic             dqm,
    output logic [15:0]      dq_in
);
    initial begin
        {cke, cs_n, ras_n, cas_n, we_n, dqm} = 6'h3e;
        ba = 2'h0;
        addr = 13'h0;
        dq_in = 16'h0;
    end
    // Drives one command after a falling edge; a no-operation or deselect shows the inverse address.
    task automatic cmd(input logic [3:0] op, input logic [12:0] a, input logic k,
                       input logic m, input logic [15:0] d);
        @(negedge clk);
        {cs_n, ras_n, cas_n, we_n} = op;
        addr = (op[3] || &op[2:0]) ? ~addr : a;
        ba = 2'h0;
        cke = k;
        dqm = m;
        dq_in = d;
    endtask
    // Programs the mode register and waits out its second clock.
    task automatic mrs(input logic [12:0] v);
        cmd(4'h0, {v[12:11], 1'b0, v[9:0]}, 1'b1, 1'b0, 16'h0);
        cmd(4'h7, 13'h0, 1'b1, 1'b0, 16'h0);
    endtask
    // Issues no-operation commands for a recovery time in clocks.
    task automatic idle(input int n);
        repeat (n) cmd(4'h7, 13'h0, 1'b1, 1'b0, 16'h0);
    endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
// Self-checking testbench for the memory device command logic.
// Assumes a 5 ns clock and a self-refresh interval shortened to 8 clocks.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [3:0] MRS = 4'h0, REF = 4'h1, WR = 4'h4, RD = 4'h5, BST = 4'h6;
    localparam logic [3:0] NOP = 4'h7;
    logic             clk = 1'b0;
    logic             rst_n = 1'b0;
    wire logic        cke, cs_n, ras_n, cas_n, we_n, dqm;
    wire logic [1:0]  ba;
    wire logic [12:0] addr;
    wire logic [15:0] dq_in;
    logic [15:0]      dq_out;
    logic [12:0]      mode_reg, refresh_row, r0;
    logic             dq_oe, cfg_error, power_down, self_refresh;
    int               num_errors = 0;
    int               compares = 0;
    int               cycles = 0;
    always #2.5 clk = ~clk;
    sdmr_ctrl_model i_sdmr_ctrl_model (.clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
        .dqm, .dq_in);
    sdmr_device #(.SR_INT_CYC(8)) i_sdmr_device (.clk, .rst_n, .cke, .cs_n, .ras_n, .cas_n,
        .we_n, .ba, .addr, .dqm, .dq_in, .dq_out, .dq_oe, .mode_reg, .cfg_error, .power_down,
        .self_refresh, .refresh_row);
    task automatic chk_bit(input string n, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %0b seen %0b", n, e, g);
        end
    endtask
    task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic c(input logic [3:0] op, input logic [12:0] a, input logic k = 1'b1,
                     input logic m = 1'b0, input logic [15:0] d = 16'h0);
        i_sdmr_ctrl_model.cmd(op, a, k, m, d);
    endtask
    task automatic nop(input int n, input logic k = 1'b1);
        repeat (n) c(NOP, 13'h0, k);
    endtask
    function automatic logic [12:0] mk(input logic [2:0] cl, input logic [2:0] bl,
                                       input logic wb);
        return {3'h0, wb, 2'h0, cl, 1'b0, bl};
    endfunction
    task automatic wr2(input logic [12:0] a, input logic [15:0] d0, d1, input logic m1);
        c(WR, a, 1'b1, 1'b0, d0);
        c(NOP, 13'h0, 1'b1, m1, d1);
        nop(1);
    endtask
    task automatic rd2(input logic [12:0] a, input int cl, input logic [15:0] w0, w1,
                       input logic m1);
        c(RD, a);
        nop(cl);
        chk_bit("dq_oe", 1'b0, dq_oe);
        c(NOP, 13'h0, 1'b1, m1);
        chk_bit("dq_oe", 1'b1, dq_oe);
        chk_word("dq_out", w0, dq_out);
        nop(1);
        chk_bit("dq_oe", !m1, dq_oe);
        if (!m1) chk_word("dq_out", w1, dq_out);
        nop(1);
        chk_bit("dq_oe", 1'b0, dq_oe);
    endtask
    task automatic t_mode();
        logic [12:0] v;
        for (int i = 0; i < 32; i++) begin
            v = {4'h0, i[4:3], i[2:0], 4'h1};
            i_sdmr_ctrl_model.mrs(v);
            nop(1);
            chk_word("mode_reg", {3'h0, v}, {3'h0, mode_reg});
            chk_bit("cfg_error", i[4:3] != 0 || !(i[2:0] inside {2, 3}), cfg_error);
        end
        c(4'h8, 13'h0);
        nop(3);
        chk_word("mode_reg", {3'h0, v}, {3'h0, mode_reg});
        $display("Mode register test done");
    endtask
    task automatic t_rw();
        i_sdmr_ctrl_model.mrs(mk(3'h2, 3'h1, 1'b0));
        wr2(13'h8, 16'ha1a1, 16'hb2b2, 1'b0);
        rd2(13'h8, 2, 16'ha1a1, 16'hb2b2, 1'b0);
        wr2(13'hc, 16'h1111, 16'h2222, 1'b0);
        wr2(13'hc, 16'h3333, 16'h4444, 1'b1);
        rd2(13'hc, 2, 16'h3333, 16'h2222, 1'b0);
        rd2(13'hc, 2, 16'h3333, 16'h2222, 1'b1);
        i_sdmr_ctrl_model.mrs(mk(3'h3, 3'h1, 1'b1));
        wr2(13'h8, 16'h5555, 16'h6666, 1'b0);
        rd2(13'h8, 3, 16'h5555, 16'hb2b2, 1'b0);
        $display("Read and write test done");
    endtask
    task automatic t_burst();
        i_sdmr_ctrl_model.mrs(mk(3'h2, 3'h3, 1'b0));
        for (int i = 0; i < 2; i++) begin
            c(RD, (i != 0) ? 13'h400 : 13'h0);
            nop(1);
            c(BST, 13'h0);
            nop(4);
            chk_bit("dq_oe", i[0], dq_oe);
            nop(6);
        end
        c(WR, 13'h10);
        for (int i = 1; i < 8; i++) c(NOP, 13'h0, 1'b1, 1'b0, 16'(i));
        nop(1);
        c(RD, 13'h10);
        nop(1);
        nop(4, 1'b0);
        nop(2);
        chk_bit("dq_oe", 1'b1, dq_oe);
        chk_word("dq_out", 16'h0, dq_out);
        nop(1);
        chk_word("dq_out", 16'h1, dq_out);
        nop(12);
        $display("Burst stop and suspend test done");
    endtask
    task automatic t_power();
        c(REF, 13'h0);
        i_sdmr_ctrl_model.idle(12);
        chk_word("refresh_row", 16'h1, {3'h0, refresh_row});
        c(REF, 13'h0, 1'b0);
        c(MRS, 13'h0, 1'b0);
        nop(2, 1'b0);
        chk_bit("self_refresh", 1'b1, self_refresh);
        r0 = refresh_row;
        nop(16, 1'b0);
        chk_word("refresh_row", {3'h0, r0 + 13'h2}, {3'h0, refresh_row});
        nop(3);
        chk_bit("self_refresh", 1'b0, self_refresh);
        chk_word("mode_reg", {3'h0, mk(3'h2, 3'h3, 1'b0)}, {3'h0, mode_reg});
        i_sdmr_ctrl_model.idle(12);
        nop(4, 1'b0);
        chk_bit("power_down", 1'b1, power_down);
        c(RD, 13'h10, 1'b0);
        nop(3);
        chk_bit("power_down", 1'b0, power_down);
        i_sdmr_ctrl_model.idle(4);
        chk_bit("dq_oe", 1'b0, dq_oe);
        $display("Refresh and power test done");
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        nop(2);
        chk_word("mode_reg", 16'h0, {3'h0, mode_reg});
        t_mode();
        t_rw();
        t_burst();
        t_power();
        close_out();
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            close_out();
        end
    end
endmodule
`default_nettype wire
